//--- debug_port_pkg.sv
package debug_port_pkg;
   // ----------------
   // instruction codes
   // ----------------
   localparam logic [3:0] IR_DEVICE_ID = 4'h0;
   localparam logic [3:0] IR_SAMPLE_PRELOAD = 4'h2;
   localparam logic [3:0] IR_SAMPLE = 4'h3;
   localparam logic [3:0] IR_EXTEST = 4'h4;
   localparam logic [3:0] IR_CORE_DP_A = 4'h8;
   localparam logic [3:0] IR_HIGHZ = 4'h9;
   localparam logic [3:0] IR_CORE_DP_B = 4'hA;
   localparam logic [3:0] IR_CORE_DP_C = 4'hB;
   localparam logic [3:0] IR_CLAMP = 4'hC;
   localparam logic [3:0] IR_CORE_ID = 4'hE;
   localparam logic [3:0] IR_BYPASS = 4'hF;
   localparam logic [3:0] IR_RESET = IR_CORE_ID;
   // ----------------
   // link mode switching
   // ----------------
   localparam logic [15:0] SWITCH_PATTERN = 16'h79E7;
   localparam logic [5:0] SWITCH_HIGH_CYCLES = 6'h33;
   localparam logic [4:0] CMD_STORE_FORMAT = 5'h03;
   localparam logic [2:0] CTRL_LEVEL_NEEDED = 3'h2;
   // ----------------
   // access port registers
   // ----------------
   localparam logic [31:0] ADDR_STATUS = 32'h0100_0000;
   localparam logic [31:0] ADDR_CONTROL = 32'h0100_0004;
   localparam logic [31:0] ADDR_IDENT = 32'h0100_00FC;
   localparam logic [31:0] IDENT_VALUE = 32'h0A5A_0001; // arbitrary value
   localparam logic [8:0] CONTROL_RESET = 9'h000;
   localparam int CTL_ERASE = 0;
   localparam int CTL_DBG_DISABLE = 1;
   localparam int CTL_HALT_REQ = 2;
   localparam int CTL_SYS_RESET = 3;
   localparam int CTL_CORE_HOLD = 4;
   localparam int CTL_DEEP_REQ = 5;
   localparam int CTL_DEEP_ACK = 6;
   localparam int CTL_STAT_ACK = 7;
   localparam int CTL_TS_FREEZE = 8;
   localparam int DR_ID_LEN = 32;
   localparam int BSR_LEN = 8;
   typedef enum logic [1:0] {MODE_SCAN, MODE_SERIAL_WIRE, MODE_COMPACT} link_mode_e;
   // chip-side status inputs
   typedef struct packed {
      logic erase_started;
      logic erase_done;
      logic mass_erase_enabled;
      logic secure;
      logic flash_ready;
      logic sys_in_reset;
      logic core_halted;
      logic sleep_deep;
      logic sleeping;
      logic low_leak_exit;
      logic deep_stop_exit;
      logic deep_stop_entry;
      logic recovery_por;
   } chip_status_s;
   // access port request
   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] data;
   } ap_req_s;
endpackage

//--- debug_port_tap.sv
`timescale 1ns/1ns
// Contract
// RQ1 - link starts in four-wire scan mode, switches only on defined sequences
// RQ2 - over 50 high, pattern 0x79E7 msb first, over 50 high enters serial wire
// RQ3 - reset, control level 2 by zero-bit scans, command 00011 enters compact mode
// RQ4 - after power-on all debug pins except test reset take scan functions
// RQ5 - system and core taps share one instruction decode and muxed output
// RQ6 - instruction register loads 1110 at power-on reset
// RQ7 - four-bit instruction, 0000 selects device identification register
// RQ8 - 0010 and 0011 select boundary register without disturbing operation
// RQ9 - 0100 selects boundary register, drives preload, asserts functional reset
// RQ10 - 1001 selects bypass, floats outputs, asserts functional reset
// RQ11 - 1100 selects bypass, holds preload on pins, asserts functional reset
// RQ12 - 1111 and unassigned codes select bypass
// RQ13 - 1000, 1010, 1011, 1110 routed to core debug port controller
// RQ14 - access port registers only over link: status, control, identity
// RQ15 - control bit 0 requests erase, cleared on completion, sticks if disabled
// RQ16 - control bit 1 disables debug, overriding core debug enable
// RQ17 - control bit 2 halts core, waking it from stop or wait
// RQ18 - control bit 3 holds system in reset while set
// RQ19 - control bit 4 holds core in reset after sequencing; clear releases
// RQ20 - bit 5 captured on deep stop entry; reset held until bit 6; recovery clears
// RQ21 - bit 7 acknowledges exit status; device clears those status bits
// RQ22 - bit 8 freezes timestamp counter during debug halt
// RQ23 - status bit 0 acknowledges erase, cleared on reset and launch
// RQ24 - status bits 9 and 10 flag stop exits until acknowledged
// RQ25 - control bits 9 to 31 read zero and ignore writes
module debug_port_tap (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // link pins
   input wire logic test_clock_pin,
   input wire logic mode_select_data_pin,
   input wire logic test_data_in_pin,
   input wire logic test_reset_n_pin,
   output logic test_out_trace_pin,
   output logic test_out_oe_n,
   // access port requests from the core debug port
   input debug_port_pkg::ap_req_s ap_req,
   output logic [31:0] ap_rdata,
   output logic ap_rvalid,
   // chip side
   input debug_port_pkg::chip_status_s chip,
   input wire logic [7:0] bsr_capture,
   output logic [7:0] bsr_drive,
   output logic bsr_drive_en,
   output logic pins_float,
   output logic functional_reset,
   output logic core_dp_select,
   output logic [3:0] core_dp_instr,
   output debug_port_pkg::link_mode_e link_mode,
   output logic pins_scan_function,
   output logic erase_launch,
   output logic debug_disable,
   output logic halt_request,
   output logic system_reset_hold,
   output logic core_reset_hold,
   output logic timestamp_freeze
);
   // ------------------------------------------------------------
   // pin synchronisers and edge finding
   // ------------------------------------------------------------
   logic [1:0] tck_s, tms_s, tdi_s, trst_s;
   logic tck_d;
   always_ff @(posedge sys_clk)
   begin
      tck_s <= {tck_s[0], test_clock_pin};
      tms_s <= {tms_s[0], mode_select_data_pin};
      tdi_s <= {tdi_s[0], test_data_in_pin};
      trst_s <= {trst_s[0], test_reset_n_pin};
      tck_d <= tck_s[1];
   end
   wire tck_rise = tck_s[1] & ~tck_d;
   wire tck_fall = ~tck_s[1] & tck_d;
   wire tms = tms_s[1];
   wire tdi = tdi_s[1];
   wire trst_n = trst_s[1];

   // ------------------------------------------------------------
   // tap state machine
   // ------------------------------------------------------------
   typedef enum logic [3:0] {RESET_ST, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR,
      UPD_DR, SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR} tap_state_e;
   tap_state_e state, next_state;
   always_comb
   begin
      unique case (state)
         RESET_ST: next_state = tms ? RESET_ST : IDLE;
         IDLE: next_state = tms ? SEL_DR : IDLE;
         SEL_DR: next_state = tms ? SEL_IR : CAP_DR;
         CAP_DR: next_state = tms ? EX1_DR : SH_DR;
         SH_DR: next_state = tms ? EX1_DR : SH_DR;
         EX1_DR: next_state = tms ? UPD_DR : PA_DR;
         PA_DR: next_state = tms ? EX2_DR : PA_DR;
         EX2_DR: next_state = tms ? UPD_DR : SH_DR;
         UPD_DR: next_state = tms ? SEL_DR : IDLE;
         SEL_IR: next_state = tms ? RESET_ST : CAP_IR;
         CAP_IR: next_state = tms ? EX1_IR : SH_IR;
         SH_IR: next_state = tms ? EX1_IR : SH_IR;
         EX1_IR: next_state = tms ? UPD_IR : PA_IR;
         PA_IR: next_state = tms ? EX2_IR : PA_IR;
         EX2_IR: next_state = tms ? UPD_IR : SH_IR;
         UPD_IR: next_state = tms ? SEL_DR : IDLE;
      endcase
   end
   wire tap_reset = reset | ~trst_n;
   logic [3:0] ir, ir_shift;
   logic [31:0] dr_shift;
   logic [7:0] bsr_preload;
   always_ff @(posedge sys_clk)
   begin
      if (tap_reset)
      begin
         state <= RESET_ST;
         ir <= debug_port_pkg::IR_RESET; // see RQ6
      end
      else if (tck_rise && link_mode == debug_port_pkg::MODE_SCAN)
      begin
         state <= next_state;
         if (state == UPD_IR)
            ir <= ir_shift; // see RQ7
         if (state == RESET_ST)
            ir <= debug_port_pkg::IR_RESET; // see RQ6
      end
   end

   // ------------------------------------------------------------
   // shared instruction decode
   // ------------------------------------------------------------
   wire sel_id = ir == debug_port_pkg::IR_DEVICE_ID; // see RQ7
   wire sel_bsr = ir == debug_port_pkg::IR_SAMPLE_PRELOAD || ir == debug_port_pkg::IR_SAMPLE
      || ir == debug_port_pkg::IR_EXTEST; // see RQ8
   wire sel_core = ir == debug_port_pkg::IR_CORE_DP_A || ir == debug_port_pkg::IR_CORE_DP_B
      || ir == debug_port_pkg::IR_CORE_DP_C || ir == debug_port_pkg::IR_CORE_ID; // see RQ13
   wire drive_pre = ir == debug_port_pkg::IR_EXTEST || ir == debug_port_pkg::IR_CLAMP; // RQ9 RQ11
   wire floating = ir == debug_port_pkg::IR_HIGHZ; // see RQ10
   wire func_rst = drive_pre | floating; // see RQ9
   // everything else, 1111 included, falls to bypass
   wire sel_bypass = ~sel_id & ~sel_bsr & ~sel_core; // see RQ12

   // data and instruction shifting; preload only under the preload code
   always_ff @(posedge sys_clk)
   begin
      if (tck_rise && link_mode == debug_port_pkg::MODE_SCAN)
      begin
         if (state == CAP_IR)
            ir_shift <= 4'h1;
         if (state == SH_IR)
            ir_shift <= {tdi, ir_shift[3:1]};
         if (state == CAP_DR)
            dr_shift <= sel_id ? debug_port_pkg::IDENT_VALUE
               : sel_bsr ? {24'h000000, bsr_capture} : 32'h0000_0000; // see RQ8
         if (state == SH_DR)
            dr_shift <= sel_bsr ? {24'h000000, tdi, dr_shift[7:1]}
               : sel_bypass ? {31'h0000_0000, tdi} : {tdi, dr_shift[31:1]};
         if (state == UPD_DR && ir == debug_port_pkg::IR_SAMPLE_PRELOAD)
            bsr_preload <= dr_shift[7:0];
      end
   end
   // output muxed by instruction, core port drives its own data elsewhere
   wire scan_out = (state == SH_IR) ? ir_shift[0] : dr_shift[0]; // see RQ5
   wire scan_drive = state == SH_IR || (state == SH_DR && !sel_core);

   // ------------------------------------------------------------
   // serial wire and compact mode switch detection
   // ------------------------------------------------------------
   logic [5:0] high_count;
   logic [15:0] pat;
   logic [4:0] pat_len;
   logic pat_ok;
   logic [2:0] ctrl_level;
   logic [4:0] cmd_shift;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         link_mode <= debug_port_pkg::MODE_SCAN; // see RQ1
         high_count <= 6'h00;
         pat <= 16'h0000;
         pat_len <= 5'h00;
         pat_ok <= 1'b0;
         ctrl_level <= 3'h0;
         cmd_shift <= 5'h00;
      end
      else if (tck_rise && link_mode == debug_port_pkg::MODE_SCAN)
      begin
         high_count <= tms ? (high_count == 6'h3F ? high_count : high_count + 6'h01) : 6'h00;
         // pattern bits are collected only after a long high run
         if (high_count >= debug_port_pkg::SWITCH_HIGH_CYCLES && !tms)
         begin
            pat <= {15'h0000, 1'b0};
            pat_len <= 5'h01;
            pat_ok <= 1'b0;
         end
         else if (pat_len != 5'h00 && pat_len < 5'h10)
         begin
            pat <= {pat[14:0], tms};
            pat_len <= pat_len + 5'h01;
         end
         else if (pat_len == 5'h10)
         begin
            pat_ok <= pat == debug_port_pkg::SWITCH_PATTERN;
            pat_len <= 5'h00;
         end
         if (pat_ok && high_count >= debug_port_pkg::SWITCH_HIGH_CYCLES)
            link_mode <= debug_port_pkg::MODE_SERIAL_WIRE; // see RQ2
         // zero-bit scans raise control level; simplified as any dr update under bypass
         if (state == RESET_ST)
            ctrl_level <= 3'h0;
         else if (state == UPD_DR && sel_bypass && ctrl_level < 3'h7)
            ctrl_level <= ctrl_level + 3'h1;
         if (state == SH_DR)
            cmd_shift <= {cmd_shift[3:0], tdi};
         if (state == UPD_DR && ctrl_level >= debug_port_pkg::CTRL_LEVEL_NEEDED
            && cmd_shift == debug_port_pkg::CMD_STORE_FORMAT)
            link_mode <= debug_port_pkg::MODE_COMPACT; // see RQ3
      end
   end

   // ------------------------------------------------------------
   // access port registers
   // ------------------------------------------------------------
   logic [8:0] control;
   logic erase_ack, low_exit, deep_exit, deep_req_latched;
   wire wr_ctl = ap_req.valid & ap_req.write & (ap_req.addr == debug_port_pkg::ADDR_CONTROL);
   wire launch = wr_ctl & ap_req.data[debug_port_pkg::CTL_ERASE] & ~control[0];
   wire status_ack = control[debug_port_pkg::CTL_STAT_ACK];
   wire [31:0] status_word = {13'h0000, chip.sleeping, chip.sleep_deep, chip.core_halted,
      5'h00, deep_exit, low_exit, 3'h0, chip.mass_erase_enabled, 1'b0, ~chip.sys_in_reset,
      chip.secure, chip.flash_ready, erase_ack};
   always_ff @(posedge sys_clk)
   begin
      if (reset || chip.recovery_por)
      begin
         control <= debug_port_pkg::CONTROL_RESET; // see RQ20
         erase_ack <= 1'b0; // see RQ23
      end
      else
      begin
         if (wr_ctl)
            control <= ap_req.data[8:0]; // see RQ25
         // erase bit is hardware cleared on completion only when enabled
         if (chip.erase_done && chip.mass_erase_enabled)
            control[0] <= 1'b0; // see RQ15
         // a start in the launch cycle wins, so the acknowledge is never lost
         if (chip.erase_started && chip.mass_erase_enabled)
            erase_ack <= 1'b1; // see RQ23
         else if (launch)
            erase_ack <= 1'b0;
      end
   end
   // sticky exit flags, set beats acknowledge
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         low_exit <= 1'b0;
         deep_exit <= 1'b0;
         deep_req_latched <= 1'b0;
      end
      else
      begin
         low_exit <= chip.low_leak_exit | (low_exit & ~status_ack); // see RQ24
         deep_exit <= chip.deep_stop_exit | (deep_exit & ~status_ack); // see RQ21
         if (chip.deep_stop_entry)
            deep_req_latched <= control[debug_port_pkg::CTL_DEEP_REQ]; // see RQ20
         else if (control[debug_port_pkg::CTL_DEEP_ACK])
            deep_req_latched <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ap_rdata <= 32'h0000_0000;
         ap_rvalid <= 1'b0;
         test_out_trace_pin <= 1'b0;
         test_out_oe_n <= 1'b1;
         bsr_drive <= 8'h00;
         bsr_drive_en <= 1'b0;
         pins_float <= 1'b0;
         functional_reset <= 1'b0;
         core_dp_select <= 1'b0;
         core_dp_instr <= debug_port_pkg::IR_RESET;
         pins_scan_function <= 1'b1; // see RQ4
         erase_launch <= 1'b0;
         debug_disable <= 1'b0;
         halt_request <= 1'b0;
         system_reset_hold <= 1'b0;
         core_reset_hold <= 1'b0;
         timestamp_freeze <= 1'b0;
      end
      else
      begin
         ap_rvalid <= ap_req.valid & ~ap_req.write;
         ap_rdata <= ap_req.addr == debug_port_pkg::ADDR_STATUS ? status_word
            : ap_req.addr == debug_port_pkg::ADDR_CONTROL ? {23'h000000, control}
            : ap_req.addr == debug_port_pkg::ADDR_IDENT ? debug_port_pkg::IDENT_VALUE
            : 32'h0000_0000; // see RQ14
         // output changes on the falling test clock edge, as in scan practice
         if (tck_fall)
         begin
            test_out_trace_pin <= scan_out;
            test_out_oe_n <= ~scan_drive;
         end
         bsr_drive <= bsr_preload;
         bsr_drive_en <= drive_pre; // see RQ11
         pins_float <= floating; // see RQ10
         functional_reset <= func_rst; // see RQ9
         core_dp_select <= sel_core; // see RQ13
         core_dp_instr <= ir;
         pins_scan_function <= link_mode == debug_port_pkg::MODE_SCAN; // see RQ4
         erase_launch <= launch; // see RQ15
         debug_disable <= control[debug_port_pkg::CTL_DBG_DISABLE]; // see RQ16
         halt_request <= control[debug_port_pkg::CTL_HALT_REQ]; // see RQ17
         system_reset_hold <= control[debug_port_pkg::CTL_SYS_RESET]
            | (deep_req_latched & ~control[debug_port_pkg::CTL_DEEP_ACK]); // see RQ18
         core_reset_hold <= control[debug_port_pkg::CTL_CORE_HOLD]; // see RQ19
         timestamp_freeze <= control[debug_port_pkg::CTL_TS_FREEZE]
            & chip.core_halted; // see RQ22
      end
   end
endmodule // debug_port_tap

//--- debug_port_tap_monitor.sv
`timescale 1ns/1ns
module debug_port_tap_monitor (
   // clock and reset
   input wire logic sys_clk,
   input wire logic reset,
   // access port
   input debug_port_pkg::ap_req_s ap_req,
   input wire logic [31:0] ap_rdata,
   input wire logic ap_rvalid,
   // chip side
   input wire logic bsr_drive_en,
   input wire logic pins_float,
   input wire logic functional_reset,
   input wire logic core_dp_select,
   input wire logic [3:0] core_dp_instr,
   input debug_port_pkg::link_mode_e link_mode,
   input wire logic pins_scan_function,
   input wire logic erase_launch,
   input wire logic debug_disable,
   input wire logic system_reset_hold
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // request decode, shared by several checks
   wire logic rd_req = ap_req.valid && !ap_req.write;
   wire logic wr_ctl = ap_req.valid && ap_req.write && ap_req.addr == debug_port_pkg::ADDR_CONTROL;
   wire logic rd_id = rd_req && ap_req.addr == debug_port_pkg::ADDR_IDENT;
   wire logic rd_none = rd_req && ap_req.addr != debug_port_pkg::ADDR_IDENT
      && ap_req.addr != debug_port_pkg::ADDR_STATUS && ap_req.addr != debug_port_pkg::ADDR_CONTROL;
   // ----------------
   // assertions
   // ----------------
   read_answer_a: assert property (rd_req |=> ap_rvalid) else $error("read not answered");
   answer_cause_a: assert property (ap_rvalid |-> $past(rd_req)) else $error("stray answer");
   ident_value_a: assert property (rd_id |=> ap_rdata == debug_port_pkg::IDENT_VALUE)
      else $error("identity value wrong");
   unmapped_zero_a: assert property (rd_none |=> ap_rdata == 32'h0) else $error("unmapped not zero");
   reset_hold_a: assert property (wr_ctl && ap_req.data[3] |-> ##[1:3] system_reset_hold)
      else $error("system reset not held");
   debug_off_a: assert property (wr_ctl && ap_req.data[1] |-> ##[1:3] debug_disable)
      else $error("debug not disabled");
   core_route_a: assert property (core_dp_select |-> core_dp_instr inside {4'h8, 4'hA, 4'hB, 4'hE})
      else $error("bad core routing");
   float_reset_a: assert property (pins_float |-> functional_reset) else $error("float without reset");
   drive_reset_a: assert property (bsr_drive_en |-> functional_reset) else $error("drive without reset");
   scan_start_a: assert property ($fell(reset) |-> link_mode == debug_port_pkg::MODE_SCAN
      && pins_scan_function) else $error("not in scan mode after reset");
   erase_pulse_a: assert property (erase_launch |=> !erase_launch) else $error("launch not a pulse");
   // main scenarios reached
   cover property (rd_id);
   cover property (pins_float);
   cover property (link_mode == debug_port_pkg::MODE_SERIAL_WIRE);
endmodule // debug_port_tap_monitor

bind debug_port_tap debug_port_tap_monitor mon (.sys_clk(sys_clk), .reset(reset), .ap_req(ap_req),
   .ap_rdata(ap_rdata), .ap_rvalid(ap_rvalid), .bsr_drive_en(bsr_drive_en), .pins_float(pins_float),
   .functional_reset(functional_reset), .core_dp_select(core_dp_select),
   .core_dp_instr(core_dp_instr), .link_mode(link_mode), .pins_scan_function(pins_scan_function),
   .erase_launch(erase_launch), .debug_disable(debug_disable), .system_reset_hold(system_reset_hold));

//--- debug_probe_model.sv
`timescale 1ns/1ns
module debug_probe_model (
   // link pins toward the device
   output logic tck,
   output logic tms,
   output logic tdi,
   output logic trst_n,
   // scan data back
   input wire logic tdo,
   input wire logic tdo_oe_n
);
   logic last;
   // undriven output has no pull, so show the inverse of the last bit
   wire logic line = tdo_oe_n ? ~last : tdo;
   always @(tdo or tdo_oe_n)
      if (!tdo_oe_n)
         last = tdo;
   // clock rests low, data lines at their pull-up level
   initial
   begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      trst_n = 1'b1;
      last = 1'b0;
   end
   // one link cycle, 320 ns; tdo read after the rise, before it moves
   task automatic clk(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      #160 tck = 1'b1;
      #80 o = line;
      #80 tck = 1'b0;
   endtask
   // instruction scan from idle, lsb first
   task automatic ir(input logic [3:0] code);
      logic o;
      clk(1, 1, o);
      clk(1, 1, o);
      clk(0, 1, o);
      clk(0, 1, o);
      for (int k = 0; k < 4; k++)
         clk(k == 3, code[k], o);
      clk(1, 1, o);
      clk(0, 1, o);
   endtask
   // data scan of n bits from idle; n of zero gives a zero-bit scan
   task automatic dr(input int n, input logic [31:0] d, output logic [31:0] q);
      logic o;
      q = 32'h0;
      clk(1, 1, o);
      clk(0, 1, o);
      if (n == 0)
         clk(1, 1, o);
      else
      begin
         clk(0, 1, o);
         for (int k = 0; k < n; k++)
         begin
            clk(k == n - 1, d[k], o);
            q[k] = o;
         end
      end
      clk(1, 1, o);
      clk(0, 1, o);
   endtask
   // five highs bring the port to test-logic-reset, then idle
   task automatic tlr();
      logic o;
      repeat (5) clk(1, 1, o);
      clk(0, 1, o);
   endtask
   // switch to two-wire mode
   task automatic to_serial();
      logic o;
      repeat (56) clk(1, 1, o);
      for (int k = 15; k >= 0; k--)
         clk(debug_port_pkg::SWITCH_PATTERN[k], 1, o);
      repeat (56) clk(1, 1, o);
   endtask
   // pulse the test reset pin
   task automatic pin_reset();
      trst_n = 1'b0;
      #400 trst_n = 1'b1;
   endtask
endmodule // debug_probe_model

//--- debug_port_tap_test.sv
`timescale 1ns/1ns
module debug_port_tap_test;
   logic sys_clk, reset, tck, tms, tdi, trst_n, tdo, oe_n, ap_rvalid, bsr_drive_en, pins_float;
   logic functional_reset, core_dp_select, pins_scan_function, erase_launch, debug_disable;
   logic halt_request, system_reset_hold, core_reset_hold, timestamp_freeze;
   logic [31:0] ap_rdata, q;
   logic [3:0] core_dp_instr;
   logic [7:0] bsr_drive;
   logic [4:0] i;
   debug_port_pkg::ap_req_s ap_req;
   debug_port_pkg::chip_status_s chip;
   debug_port_pkg::link_mode_e link_mode;
   int err_total, checks_done;
   localparam logic [31:0] ctl_addr = debug_port_pkg::ADDR_CONTROL;
   localparam logic [31:0] sts_addr = debug_port_pkg::ADDR_STATUS;
   debug_port_tap dut (.sys_clk(sys_clk), .reset(reset), .test_clock_pin(tck),
      .mode_select_data_pin(tms), .test_data_in_pin(tdi), .test_reset_n_pin(trst_n),
      .test_out_trace_pin(tdo), .test_out_oe_n(oe_n), .ap_req(ap_req), .ap_rdata(ap_rdata),
      .ap_rvalid(ap_rvalid), .chip(chip), .bsr_capture(8'hA5), .bsr_drive(bsr_drive),
      .bsr_drive_en(bsr_drive_en), .pins_float(pins_float), .functional_reset(functional_reset),
      .core_dp_select(core_dp_select), .core_dp_instr(core_dp_instr), .link_mode(link_mode),
      .pins_scan_function(pins_scan_function), .erase_launch(erase_launch),
      .debug_disable(debug_disable), .halt_request(halt_request),
      .system_reset_hold(system_reset_hold), .core_reset_hold(core_reset_hold),
      .timestamp_freeze(timestamp_freeze));
   debug_probe_model probe (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo),
      .tdo_oe_n(oe_n));
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // one access port request, read answer waited for under a bound
   task automatic ap(input logic wr, input logic [31:0] addr, input logic [31:0] data);
      @(negedge sys_clk);
      ap_req = '{1'b1, wr, addr, data};
      @(negedge sys_clk);
      ap_req.valid = 1'b0;
      for (int n = 0; n < 4 && !wr && ap_rvalid !== 1'b1; n++)
         @(negedge sys_clk);
      if (!wr && ap_rvalid !== 1'b1)
      begin
         check(32'h0, 32'h1);
         test_done();
      end
   endtask
   task automatic rd(input logic [31:0] addr, input logic [31:0] mask, input logic [31:0] exp);
      ap(1'b0, addr, 32'h0);
      check(ap_rdata & mask, exp);
   endtask
   task automatic pulse_reset();
      reset = 1'b1;
      repeat (8) @(negedge sys_clk);
      reset = 1'b0;
   endtask
   // watchdog against a hang
   initial
   begin
      #2000000;
      check(32'h0, 32'h1);
      test_done();
   end
   initial
   begin
      err_total = 0;
      checks_done = 0;
      ap_req = '0;
      chip = '0;
      chip.flash_ready = 1'b1;
      chip.mass_erase_enabled = 1'b1;
      pulse_reset();
      check(link_mode, debug_port_pkg::MODE_SCAN);
      check(pins_scan_function, 1);
      check(core_dp_instr, 4'hE);
      $display("test reset state done");
      // ----------------
      // access port registers
      // ----------------
      ap(1, debug_port_pkg::ADDR_IDENT, 32'h0);
      rd(debug_port_pkg::ADDR_IDENT, '1, debug_port_pkg::IDENT_VALUE);
      rd(32'h0100_0008, '1, 32'h0);
      chip.core_halted = 1'b1;
      rd(sts_addr, '1, 32'h0001_002A);
      ap(1, ctl_addr, 32'hFFFF_FE00);
      rd(ctl_addr, '1, 32'h0);
      ap(1, ctl_addr, 32'h11E);
      rd(ctl_addr, '1, 32'h11E);
      check({debug_disable, halt_request, system_reset_hold, timestamp_freeze}, 4'hF);
      check(core_reset_hold, 1);
      chip.core_halted = 1'b0;
      rd(ctl_addr, '1, 32'h11E);
      check(timestamp_freeze, 0);
      ap(1, ctl_addr, 32'h0);
      rd(ctl_addr, '1, 32'h0);
      check({debug_disable, system_reset_hold, core_reset_hold}, 3'h0);
      $display("test control bits done");
      ap(1, ctl_addr, 32'h1);
      rd(sts_addr, 32'h1, 32'h0);
      chip.erase_started = 1'b1;
      rd(sts_addr, 32'h1, 32'h1);
      rd(ctl_addr, 32'h1, 32'h1);
      chip.erase_done = 1'b1;
      rd(ctl_addr, 32'h1, 32'h0);
      chip.erase_done = 1'b0;
      chip.erase_started = 1'b0;
      $display("test erase done");
      ap(1, ctl_addr, 32'h20);
      chip.deep_stop_entry = 1'b1;
      rd(ctl_addr, 32'h20, 32'h20);
      chip.deep_stop_entry = 1'b0;
      chip.deep_stop_exit = 1'b1;
      chip.low_leak_exit = 1'b1;
      rd(sts_addr, 32'h600, 32'h600);
      chip.deep_stop_exit = 1'b0;
      chip.low_leak_exit = 1'b0;
      check(system_reset_hold, 1);
      ap(1, ctl_addr, 32'h60);
      rd(sts_addr, 32'h600, 32'h600);
      check(system_reset_hold, 0);
      chip.recovery_por = 1'b1;
      rd(ctl_addr, 32'h60, 32'h0);
      chip.recovery_por = 1'b0;
      ap(1, ctl_addr, 32'h80);
      rd(sts_addr, 32'h600, 32'h0);
      ap(1, ctl_addr, 32'h0);
      chip.mass_erase_enabled = 1'b0;
      ap(1, ctl_addr, 32'h1);
      chip.erase_done = 1'b1;
      rd(ctl_addr, 32'h1, 32'h1);
      chip.erase_done = 1'b0;
      $display("test stop recovery and blocked erase done");
      // ----------------
      // scan port instructions and mode switching
      // ----------------
      pulse_reset();
      probe.tlr();
      for (i = 0; i < 16; i++)
      begin
         probe.ir(i[3:0]);
         check(functional_reset, i[3:0] inside {4'h4, 4'h9, 4'hC});
         check(pins_float, i[3:0] == 4'h9);
         check(bsr_drive_en, i[3:0] inside {4'h4, 4'hC});
         check(core_dp_select, i[3:0] inside {4'h8, 4'hA, 4'hB, 4'hE});
         if (!(i[3:0] inside {4'h0, 4'h2, 4'h3, 4'h4, 4'h8, 4'hA, 4'hB, 4'hE}))
         begin
            probe.dr(2, 32'h1, q);
            check(q[1:0], 2'b10);
         end
      end
      probe.ir(4'h0);
      probe.dr(32, 32'h0, q);
      check(q, debug_port_pkg::IDENT_VALUE);
      probe.ir(4'h3);
      probe.dr(8, 32'h0, q);
      check(q[7:0], 8'hA5);
      probe.ir(4'hF);
      probe.pin_reset();
      check(core_dp_instr, 4'hE);
      $display("test instructions done");
      probe.to_serial();
      check(link_mode, debug_port_pkg::MODE_SERIAL_WIRE);
      pulse_reset();
      check(link_mode, debug_port_pkg::MODE_SCAN);
      probe.tlr();
      probe.ir(4'hF);
      probe.dr(0, 32'h0, q);
      probe.dr(0, 32'h0, q);
      probe.dr(5, 32'h18, q);
      check(link_mode, debug_port_pkg::MODE_COMPACT);
      $display("test mode switching done");
      test_done();
   end
endmodule // debug_port_tap_test
